// [pss_sram.v]
// pipelined zero-turnaround sram core with composite select,
// burst counter, clock qualifier and a write-commit buffer.
// assumes all inputs synchronous to sys_clk_i; the wire level of the
// data bus is resolved outside from data_o and data_oe_o.
//
// Functional notes
// - load taken on edge with load low, select true, qualifier low.
// - read data driven two cycles after load while gate is low.
// - deselect after a read load does not cancel that read.
// - pending write completes through a following deselect cycle.
// - bus floats two cycles after deselect unless a read delivers.
// - select true only when both low selects low and high select high.
// - outputs float from the first clock edge after power-up.
// - undriven burst-order pin behaves as if held high.
// - qualifier high makes the edge ignored; all state holds.
// - burst counter steps four words then wraps and keeps going.
// - direction ignored on advance cycles; fixed at load.
`timescale 1ns/1ps
`include "pss_sram_regs.vh"

// pipeline timing in short, counted in live edges only:
// - a load is captured at edge e0 into stage one
// - a read launches its word at e1, so it is on the bus in the
//   cycle after e1, the second cycle counted from the load cycle
// - a write moves to stage two at e1 and takes the bus at e2
// - deselect and stop only stop new work; stage one and stage two
//   carry on, so pending reads and writes always finish
// - ignored edges freeze every register here, the buffer included
// hazard: a read of a word still queued for commit must see the
//   queued value, hence the forwarding in each lane
// limitation: the buffer drains one entry per live edge and at
//   most one write enters per live edge, so it never fills in use

// small synchronous fifo, registered pointers, honest full and empty
module pss_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = `PSS_FIFO_DEPTH,
    parameter AW = `PSS_FIFO_AW
) (
    input wire sys_clk_i,
    input wire reset_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    // full level held at the counter's width, no silent resize
    localparam [AW:0] FULL = DEPTH;
    wire push;
    wire pop;

    assign in_ready_o = (count != FULL);
    assign out_valid_o = (count != {(AW+1){1'b0}});
    assign out_data_o = store[rd_ptr];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // pointer wrap relies on depth being a power of two;
    // a push and a pop in one cycle leave the count alone
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                store[wr_ptr] <= in_data_i;
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // pss_fifo

// the memory device itself
module pss_sram #(
    parameter ADDR_W = `PSS_ADDR_W,
    parameter LANES = `PSS_LANES,
    parameter LANE_W = `PSS_LANE_W
) (
    input wire sys_clk_i,
    input wire reset_i,
    input wire [ADDR_W-1:0] addr_i,
    input wire read_write_i,
    input wire advance_or_load_i,
    input wire select_low_first_n_i,
    input wire select_pair_second_n_i,
    input wire select_pair_second_i,
    input wire clock_qualifier_n_i,
    input wire [LANES-1:0] byte_write_select_n_i,
    input wire burst_order_select_i,
    input wire burst_order_driven_i,
    input wire output_gate_n_i,
    input wire [LANES*LANE_W-1:0] data_i,
    output reg [LANES*LANE_W-1:0] data_o,
    output wire data_oe_o
);
    localparam DATA_W = LANES * LANE_W;
    localparam ENTRY_W = ADDR_W + LANES + DATA_W;
    localparam BW = `PSS_BURST_W;

    // composite select decode, used by the load path;
    // any single inactive select is enough to deselect
    function sel_true;
        input s1_n;
        input s2_n;
        input s2;
        begin
            sel_true = ~s1_n & ~s2_n & s2;
        end
    endfunction

    // stage one: operation accepted at the last live edge
    reg s1_v;
    reg s1_rd;
    reg [ADDR_W-1:0] s1_addr;
    reg [LANES-1:0] s1_bw_n;
    // stage two: operation in its data phase
    reg s2_v;
    reg s2_rd;
    reg [ADDR_W-1:0] s2_addr;
    reg [LANES-1:0] s2_bw_n;
    // burst state kept from the load
    reg b_act;
    reg b_rd;
    reg [ADDR_W-1:0] b_addr;
    reg [BW-1:0] b_cnt;
    // read output enable before the asynchronous gate
    reg rd_oe;

    reg next_v;
    reg next_rd;
    reg [ADDR_W-1:0] next_addr;
    reg [BW-1:0] next_cnt;
    reg next_act;
    reg [BW-1:0] step;

    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [ENTRY_W-1:0] fifo_out;
    wire [ENTRY_W-1:0] fifo_in;
    wire live;
    wire order_il;
    wire push_wr;
    wire [ADDR_W-1:0] head_addr;
    wire [LANES-1:0] head_bw_n;
    wire [DATA_W-1:0] head_data;
    wire [DATA_W-1:0] rd_word;

    // a full buffer stalls the core exactly like a held qualifier
    assign live = ~clock_qualifier_n_i & fifo_in_ready;
    // a floating pin reads as the pulled-up default
    assign order_il = burst_order_driven_i ? burst_order_select_i
                                           : `PSS_ORDER_DEFAULT;
    // write data taken two cycles after load, even if deselected now
    assign push_wr = live & s2_v & ~s2_rd;
    assign fifo_in = {s2_addr, s2_bw_n, data_i};
    assign head_addr = fifo_out[ENTRY_W-1 -: ADDR_W];
    assign head_bw_n = fifo_out[DATA_W+LANES-1 -: LANES];
    assign head_data = fifo_out[DATA_W-1:0];
    // gate acts without the clock; the only unregistered output term
    assign data_oe_o = rd_oe & ~output_gate_n_i;

    // next operation from the pins or the burst counter
    always @* begin
        next_v = 1'b0;
        next_rd = b_rd;
        next_addr = b_addr;
        next_cnt = b_cnt;
        next_act = b_act;
        step = `PSS_BURST_ZERO;
        if (~advance_or_load_i) begin
            if (sel_true(select_low_first_n_i, select_pair_second_n_i,
                         select_pair_second_i)) begin
                next_v = 1'b1;
                next_rd = read_write_i;
                next_addr = addr_i;
                next_cnt = `PSS_BURST_ZERO;
                next_act = 1'b1;
            end else begin
                // stop: ends the burst, leaves the pipe untouched
                next_act = 1'b0;
            end
        end else if (b_act) begin
            // direction pin ignored here, kept from the load
            next_v = 1'b1;
            next_cnt = b_cnt + `PSS_BURST_STEP;
            step = order_il ? (b_addr[BW-1:0] ^ next_cnt)
                            : (b_addr[BW-1:0] + next_cnt);
            next_addr = {b_addr[ADDR_W-1:BW], step};
        end
    end

    // pipeline and burst registers, frozen on ignored edges
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            s1_v <= 1'b0;
            s2_v <= 1'b0;
            b_act <= 1'b0;
            b_rd <= 1'b0;
            b_cnt <= `PSS_BURST_ZERO;
            s1_rd <= 1'b0;
            s2_rd <= 1'b0;
        end else if (live) begin
            s1_v <= next_v;
            s1_rd <= next_rd;
            s1_addr <= next_addr;
            s1_bw_n <= byte_write_select_n_i;
            // a pending op moves on regardless of select now
            s2_v <= s1_v;
            s2_rd <= s1_rd;
            s2_addr <= s1_addr;
            s2_bw_n <= s1_bw_n;
            b_act <= next_act;
            if (~advance_or_load_i) begin
                b_rd <= read_write_i;
                b_addr <= addr_i;
            end
            b_cnt <= next_cnt;
        end
    end

    // per-lane storage, with write-back and forwarding of queued data
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : lane
            reg [LANE_W-1:0] mem [0:(1<<ADDR_W)-1];
            reg [LANE_W-1:0] word;
            // commit the buffered write when the core is running
            always @(posedge sys_clk_i) begin
                if (live & fifo_out_valid & ~head_bw_n[g]) begin
                    mem[head_addr] <= head_data[g*LANE_W +: LANE_W];
                end
            end
            // newest write wins: bus data, then buffer head, then array
            always @* begin
                word = mem[s1_addr];
                if (fifo_out_valid & ~head_bw_n[g] & (head_addr == s1_addr)) begin
                    word = head_data[g*LANE_W +: LANE_W];
                end
                if (push_wr & ~s2_bw_n[g] & (s2_addr == s1_addr)) begin
                    word = data_i[g*LANE_W +: LANE_W];
                end
            end
            assign rd_word[g*LANE_W +: LANE_W] = word;
        end
    endgenerate

    // read data registered for delivery two cycles after its load;
    // launched one live edge after capture, so it stands in the
    // second cycle counted from the load cycle
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            rd_oe <= 1'b0;
            data_o <= {DATA_W{1'b0}};
        end else if (live) begin
            // floats unless a read reaches its data phase
            rd_oe <= s1_v & s1_rd;
            if (s1_v & s1_rd) begin
                data_o <= rd_word;
            end
        end
    end

    // write-commit buffer; drain holds while the core is suspended
    // so an ignored edge can never commit a word early
    pss_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(`PSS_FIFO_DEPTH),
        .AW(`PSS_FIFO_AW)
    ) u_wbuf (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .in_valid_i(push_wr),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(live),
        .out_data_o(fifo_out)
    );
endmodule // pss_sram

// [pss_sram_regs.vh]
// constants for the pipelined select-timed sram core
// assumes inclusion by bare name from the design file only
`ifndef PSS_SRAM_REGS_VH
`define PSS_SRAM_REGS_VH

// organisation: four byte lanes of nine bits, 128k words
`define PSS_ADDR_W 17
`define PSS_LANES 4
`define PSS_LANE_W 9
// burst counter width, four-word burst
`define PSS_BURST_W 2
`define PSS_BURST_ZERO 2'h0
`define PSS_BURST_STEP 2'h1
// write-commit buffer depth and its pointer width
`define PSS_FIFO_DEPTH 4
`define PSS_FIFO_AW 2
// level taken by an undriven burst-order pin
`define PSS_ORDER_DEFAULT 1'h1

`endif

// [pss_ctl_model.sv]
// controller model: drives write data onto the bus
// assumes the bench flags each write cycle, taken on live edges
`timescale 1ns/1ps
module pss_ctl_model (
    input wire sys_clk_i,
    input wire qual_n_i,
    input wire wr_load_i,
    input wire [35:0] wdata_i,
    output wire [35:0] data_o,
    output wire oe_o
);
    reg [1:0] pend = 2'h0;
    reg [35:0] d1 = 36'h0;
    reg [35:0] d2 = 36'h0;
    // data goes out two live edges after its write cycle
    always @(posedge sys_clk_i) begin
        if (!qual_n_i) begin
            pend <= {pend[0], wr_load_i};
            d1 <= wdata_i;
            d2 <= d1;
        end
    end
    // released bus shows the inverse, so a stale word never reads right
    assign oe_o = pend[1];
    assign data_o = pend[1] ? d2 : ~d2;
endmodule // pss_ctl_model

// [pss_sram_asserts.sv]
// pin checker for pss_sram
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module pss_sram_asserts #(parameter LANES = 4, parameter LANE_W = 9) (
    input wire sys_clk_i,
    input wire reset_i,
    input wire read_write_i,
    input wire advance_or_load_i,
    input wire select_low_first_n_i,
    input wire select_pair_second_n_i,
    input wire select_pair_second_i,
    input wire clock_qualifier_n_i,
    input wire output_gate_n_i,
    input wire [LANES*LANE_W-1:0] data_o,
    input wire data_oe_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    // decoded controls; an edge counts only when the qualifier is low
    wire live = !clock_qualifier_n_i;
    wire sel = !select_low_first_n_i && !select_pair_second_n_i && select_pair_second_i;
    wire nld = live && !advance_or_load_i;
    wire rd = nld && sel && read_write_i;
    wire gl = !output_gate_n_i;
    chk_read_latency: assert property (rd ##1 live ##1 gl |-> data_oe_o)
        else $error("read data late");
    chk_read_survives: assert property (rd ##1 (nld && !sel) ##1 gl |-> data_oe_o)
        else $error("deselect cancelled read");
    chk_idle_float: assert property ((nld && !rd) ##1 live |=> !data_oe_o)
        else $error("bus driven without read");
    chk_data_hold: assert property ((nld && !rd) ##1 live |=> $stable(data_o))
        else $error("read data moved");
    chk_gate_float: assert property (output_gate_n_i |-> !data_oe_o)
        else $error("bus driven with gate high");
    chk_power_float: assert property (disable iff (1'b0) reset_i |=> !data_oe_o)
        else $error("bus driven after reset");
    chk_qual_hold: assert property (clock_qualifier_n_i ##1 $stable(output_gate_n_i)
        |-> $stable(data_oe_o) && $stable(data_o))
        else $error("ignored edge changed outputs");
    chk_burst_stream: assert property (rd ##1 (live && advance_or_load_i) ##1 live
        ##1 gl |-> data_oe_o)
        else $error("burst word missing");
endmodule // pss_sram_asserts

bind pss_sram pss_sram_asserts #(.LANES(LANES), .LANE_W(LANE_W)) u_chk (
    .sys_clk_i, .reset_i, .read_write_i, .advance_or_load_i, .select_low_first_n_i,
    .select_pair_second_n_i, .select_pair_second_i, .clock_qualifier_n_i,
    .output_gate_n_i, .data_o, .data_oe_o);

// [tb_pss_sram.sv]
// self-checking bench for pss_sram with a controller model
// assumes design, checker and model compiled first
`timescale 1ns/1ps
module tb_pss_sram;
    localparam [2:0] SEL = 3'h1;
    reg sys_clk_i = 0, reset_i = 1, rw = 1, adv = 0, cq = 0, gate = 0;
    reg wl = 0, burst_order_select = 0, lbo_drv = 0, gnx = 0;
    reg [2:0] sel = 3'h5;
    reg [3:0] addr = 4'h0, bw = 4'hF;
    reg [35:0] wd = 36'h0;
    wire [35:0] bus, rdata;
    wire oe;
    integer bad_count = 0, tests_run = 0, k;
    pss_sram #(.ADDR_W(4)) u_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .addr_i(addr), .read_write_i(rw), .advance_or_load_i(adv),
        .select_low_first_n_i(sel[2]), .select_pair_second_n_i(sel[1]),
        .select_pair_second_i(sel[0]), .clock_qualifier_n_i(cq),
        .byte_write_select_n_i(bw), .burst_order_select_i(burst_order_select),
        .burst_order_driven_i(lbo_drv), .output_gate_n_i(gate), .data_i(bus),
        .data_o(rdata), .data_oe_o(oe));
    pss_ctl_model u_ctl (.sys_clk_i(sys_clk_i), .qual_n_i(cq), .wr_load_i(wl),
        .wdata_i(wd), .data_o(bus), .oe_o());
    initial forever #12.5 sys_clk_i = ~sys_clk_i;
    // one bus cycle: inputs change at the falling edge, outputs read after rise
    task drv(input [3:0] a, input r, input ad, input [2:0] s, input q, input w,
        input [35:0] d);
        begin
            @(negedge sys_clk_i);
            addr = a;
            rw = r;
            adv = ad;
            sel = s;
            cq = q;
            wd = d;
            bw = w ? 4'h0 : 4'hF;
            wl = w;
            gate = gnx;
            @(posedge sys_clk_i);
            #1;
        end
    endtask
    task cmp(input [35:0] got, input [35:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task rdq(input [35:0] exp);
        begin
            cmp({35'h0, oe}, 36'h1);
            cmp(rdata, exp);
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", tests_run, bad_count);
            if (bad_count == 0 && tests_run > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // two writes, each followed by a deselect
    task t_write;
        begin
            drv(4'h1, 0, 0, SEL, 0, 1, 36'h123456789);
            drv(4'h0, 1, 0, 3'h5, 0, 0, 36'h0);
            drv(4'h2, 0, 0, SEL, 0, 1, 36'hFEDCBA987);
            drv(4'h0, 1, 0, 3'h3, 0, 0, 36'h0);
            drv(4'h0, 1, 0, 3'h0, 0, 0, 36'h0);
        end
    endtask
    // read survives deselect; then a read with the gate high
    task t_read;
        begin
            drv(4'h1, 1, 0, SEL, 0, 0, 36'h0);
            drv(4'h0, 1, 0, 3'h5, 0, 0, 36'h0);
            rdq(36'h123456789);
            drv(4'h0, 1, 0, 3'h3, 0, 0, 36'h0);
            cmp({35'h0, oe}, 36'h0);
            drv(4'h2, 1, 0, SEL, 0, 0, 36'h0);
            cmp({35'h0, oe}, 36'h0);
            gnx = 1;
            drv(4'h0, 1, 0, 3'h0, 0, 0, 36'h0);
            cmp({35'h0, oe}, 36'h0);
            cmp(rdata, 36'hFEDCBA987);
            gnx = 0;
            for (k = 0; k < 3; k = k + 1) begin
                drv(4'h1, 1, 0, k == 0 ? 3'h5 : k == 1 ? 3'h3 : 3'h0, 0, 0, 36'h0);
                drv(4'h0, 1, 0, 3'h5, 0, 0, 36'h0);
                cmp({35'h0, oe}, 36'h0);
                drv(4'h0, 1, 0, 3'h5, 0, 0, 36'h0);
            end
        end
    endtask
    // ignored edges stretch the read pipe
    task t_qual;
        begin
            drv(4'h2, 1, 0, SEL, 0, 0, 36'h0);
            drv(4'h1, 0, 0, SEL, 1, 1, 36'h0);
            drv(4'h1, 0, 0, SEL, 1, 1, 36'h0);
            cmp({35'h0, oe}, 36'h0);
            drv(4'h0, 1, 0, 3'h5, 0, 0, 36'h0);
            rdq(36'hFEDCBA987);
        end
    endtask
    // burst write from 0, then read bursts from 1 in both orders
    task t_burst(input lin);
        begin
            @(negedge sys_clk_i);
            lbo_drv = lin;
            drv(4'h0, 0, 0, SEL, 0, 1, 36'hA00000000);
            for (k = 1; k < 4; k = k + 1)
                drv(4'h0, 1, 1, 3'h5, 0, 1, 36'hA00000000 + k);
            drv(4'h0, 1, 0, 3'h5, 0, 0, 36'h0);
            drv(4'h0, 1, 0, 3'h5, 0, 0, 36'h0);
            drv(4'h1, 1, 0, SEL, 0, 0, 36'h0);
            drv(4'h0, 0, 1, 3'h5, 0, 0, 36'h0);
            rdq(36'hA00000001);
            for (k = 0; k < 4; k = k + 1) begin
                drv(4'h0, 0, k < 3, 3'h5, 0, 0, 36'h0);
                rdq(36'hA00000000 + (lin ? (2 + k) & 3 : 1 ^ ((k + 1) & 3)));
            end
        end
    endtask
    initial begin
        repeat (4) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        reset_i = 0;
        cmp({35'h0, oe}, 36'h0);
        t_write;
        t_read;
        t_qual;
        t_burst(0);
        t_burst(1);
        close_out;
    end
    // about 55 cycles of tests; 2000 cycles means a hang
    initial begin
        #50000;
        bad_count = bad_count + 1;
        close_out;
    end
endmodule // tb_pss_sram
